// ==== pkg/sfp_map.svh ====
// Functional notes
// - data input bits are taken on rising serial clock edges
// - output data shifts on falling edge, or rising edge when read-edge select set
// - data output floats while chip select high or pause input low
// - commands ignored until one chip select low-to-high transition after power-up
// - active only while selected; standby waits for programming to finish
// - write-protect input low rejects every array sector write
// - write-protect high allows writes outside the protected sector range only
// - multi-function pin unused by default; setting picks pause input or ready/busy
// - after a sector write array reports busy about 5 ms, refusing access
`ifndef SFP_MAP_SVH
`define SFP_MAP_SVH
`define SFP_CLK_MHZ      125
`define SFP_TWP_US       5000
`define SFP_TWP_CYC      (`SFP_TWP_US * `SFP_CLK_MHZ)
`define SFP_SEC_W        11
`define SFP_BIT_LAST     3'h7
`define SFP_BYTE_MSB     7
`define SFP_IDLE_BYTE    8'hFF
// sync reset matches pin idle levels: sck rests low, the rest high, so no false edge
`define SFP_SYNC_RST     5'h1E
`define SFP_MFP_NC       2'h0
`define SFP_MFP_PAUSE    2'h1
`define SFP_MFP_RDYBSY   2'h2
`endif

// ==== pkg/sfp_pkg.sv ====
package sfp_pkg;
  typedef enum logic {SFP_ARR_IDLE, SFP_ARR_BUSY} sfp_arr_state_t;
  typedef logic [7:0] sfp_byte_t;
endpackage

// ==== hdl/sfp_buf2.sv ====
`timescale 1ns/10ps
// two-entry buffer; registered outputs, full only when both slots hold data
module sfp_buf2 #(
  parameter int W = 9
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  logic [W-1:0] head_q, head_d, tail_q, tail_d;
  logic [1:0]   cnt_q, cnt_d;
  logic         push, pop;
  logic         vld_q, rdy_q;

  always_comb begin
    push   = in_valid && (cnt_q != 2'h2);
    pop    = out_ready && (cnt_q != 2'h0);
    head_d = head_q;
    tail_d = tail_q;
    cnt_d  = cnt_q;
    case ({push, pop})
      2'b10: begin
        if (cnt_q == 2'h0) head_d = in_data;
        else tail_d = in_data;
        cnt_d = cnt_q + 2'h1;
      end
      2'b01: begin
        head_d = tail_q;
        cnt_d  = cnt_q - 2'h1;
      end
      2'b11: begin
        if (cnt_q == 2'h1) head_d = in_data;
        else begin
          head_d = tail_q;
          tail_d = in_data;
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      head_q <= '0;
      tail_q <= '0;
      cnt_q  <= 2'h0;
      vld_q  <= 1'b0;
      rdy_q  <= 1'b1;
    end else begin
      head_q <= head_d;
      tail_q <= tail_d;
      cnt_q  <= cnt_d;
      vld_q  <= cnt_d != 2'h0;
      rdy_q  <= cnt_d != 2'h2;
    end
  end

  assign out_data  = head_q;
  assign out_valid = vld_q;
  assign in_ready  = rdy_q;
endmodule

// ==== hdl/sfp_frontend.sv ====
`timescale 1ns/10ps
`include "sfp_map.svh"
module sfp_frontend
  import sfp_pkg::*;
#(
  parameter int TWP_CYC = `SFP_TWP_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 sck,
  input  wire logic                 cs_n,
  input  wire logic                 si,
  input  wire logic                 wp_n,
  input  wire logic                 mfp_i,
  output logic                      so_o,
  output logic                      so_oe,
  output logic                      mfp_o,
  output logic                      mfp_oe,
  input  wire logic                 read_edge_select,
  input  wire logic [1:0]           mfp_func,
  input  wire logic [`SFP_SEC_W-1:0] prot_lo,
  input  wire logic [`SFP_SEC_W-1:0] prot_hi,
  input  wire logic                 prot_en,
  output logic [7:0]                rx_data,
  output logic                      rx_first,
  output logic                      rx_valid,
  input  wire logic                 rx_ready,
  output logic                      rx_overrun,
  input  wire logic [7:0]           tx_data,
  input  wire logic                 tx_valid,
  output logic                      tx_ready,
  input  wire logic                 wr_req,
  input  wire logic [`SFP_SEC_W-1:0] wr_sector,
  output logic                      wr_grant,
  output logic                      wr_reject,
  input  wire logic                 rd_req,
  output logic                      rd_grant,
  output logic                      rd_reject,
  output logic                      arr_busy,
  output logic                      standby
);
  // synchronisers: stage a feeds stage b only
  logic [4:0] sa_q, sb_q;
  logic       sck_prev_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sa_q       <= `SFP_SYNC_RST;
      sb_q       <= `SFP_SYNC_RST;
      sck_prev_q <= 1'b0;
    end else begin
      sa_q       <= {mfp_i, wp_n, si, cs_n, sck};
      sb_q       <= sa_q;
      sck_prev_q <= sb_q[0];
    end
  end

  logic sck_s, cs_s, si_s, wp_s, hold_s;
  assign sck_s  = sb_q[0];
  assign cs_s   = sb_q[1];
  assign si_s   = sb_q[2];
  assign wp_s   = sb_q[3];
  assign hold_s = sb_q[4];

  logic sck_rise, sck_fall, pause, out_edge;
  assign sck_rise = sck_s && !sck_prev_q;
  assign sck_fall = !sck_s && sck_prev_q;
  assign pause    = (mfp_func == `SFP_MFP_PAUSE) && !hold_s;
  assign out_edge = read_edge_select ? sck_rise : sck_fall;

  function automatic logic in_prot(input logic [`SFP_SEC_W-1:0] s,
                                   input logic [`SFP_SEC_W-1:0] lo,
                                   input logic [`SFP_SEC_W-1:0] hi);
    in_prot = (s >= lo) && (s <= hi);
  endfunction

  // link side: arming, shifting, output drive
  logic       armed_q, armed_d, cs_prev_q, cs_prev_d;
  logic [2:0] bit_cnt_q, bit_cnt_d, obit_q, obit_d;
  logic [7:0] rx_sh_q, rx_sh_d, tx_sh_q, tx_sh_d;
  logic       first_q, first_d, so_q, so_d, so_oe_q, so_oe_d;
  logic       ovr_q, ovr_d, txr_q, txr_d;
  logic       rx_push, buf_in_ready, run;
  logic [7:0] rx_byte;

  assign run = armed_q && !cs_s && !pause;

  always_comb begin
    armed_d   = armed_q;
    cs_prev_d = cs_s;
    bit_cnt_d = bit_cnt_q;
    obit_d    = obit_q;
    rx_sh_d   = rx_sh_q;
    tx_sh_d   = tx_sh_q;
    first_d   = first_q;
    so_d      = so_q;
    ovr_d     = 1'b0;
    txr_d     = 1'b0;
    rx_push   = 1'b0;
    rx_byte   = {rx_sh_q[6:0], si_s};
    if (cs_s && !cs_prev_q) armed_d = 1'b1;
    if (cs_s) begin
      bit_cnt_d = 3'h0;
      obit_d    = 3'h0;
      first_d   = 1'b1;
      tx_sh_d   = tx_valid ? tx_data : `SFP_IDLE_BYTE;
      txr_d     = tx_valid && !tx_ready;
      so_d      = tx_sh_d[`SFP_BYTE_MSB];
    end else if (run) begin
      if (sck_rise) begin
        rx_sh_d   = rx_byte;
        bit_cnt_d = bit_cnt_q + 3'h1;
        if (bit_cnt_q == `SFP_BIT_LAST) begin
          rx_push = 1'b1;
          first_d = 1'b0;
          ovr_d   = !buf_in_ready;
        end
      end
      if (out_edge) begin
        obit_d = obit_q + 3'h1;
        if (obit_q == `SFP_BIT_LAST) begin
          tx_sh_d = tx_valid ? tx_data : `SFP_IDLE_BYTE;
          txr_d   = tx_valid;
        end else begin
          tx_sh_d = {tx_sh_q[6:0], 1'b0};
        end
        so_d = tx_sh_d[`SFP_BYTE_MSB];
      end
    end
    so_oe_d = armed_q && !cs_s && !pause;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      armed_q   <= 1'b0;
      cs_prev_q <= 1'b1;
      bit_cnt_q <= 3'h0;
      obit_q    <= 3'h0;
      rx_sh_q   <= 8'h00;
      tx_sh_q   <= `SFP_IDLE_BYTE;
      first_q   <= 1'b1;
      so_q      <= 1'b1;
      so_oe_q   <= 1'b0;
      ovr_q     <= 1'b0;
      txr_q     <= 1'b0;
    end else begin
      armed_q   <= armed_d;
      cs_prev_q <= cs_prev_d;
      bit_cnt_q <= bit_cnt_d;
      obit_q    <= obit_d;
      rx_sh_q   <= rx_sh_d;
      tx_sh_q   <= tx_sh_d;
      first_q   <= first_d;
      so_q      <= so_d;
      so_oe_q   <= so_oe_d;
      ovr_q     <= ovr_d;
      txr_q     <= txr_d;
    end
  end

  // received bytes wait here so a slow consumer loses nothing short of a third byte
  sfp_buf2 #(.W(9)) u_rxbuf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   ({first_q, rx_byte}),
    .in_valid  (rx_push),
    .in_ready  (buf_in_ready),
    .out_data  ({rx_first, rx_data}),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  // array side: protection check and program busy timer
  sfp_arr_state_t st_q, st_d;
  logic [19:0]    tmr_q, tmr_d;
  logic           wg_q, wg_d, wj_q, wj_d, rg_q, rg_d, rj_q, rj_d;
  logic           sb_q2, sb_d2, mo_q, mo_d, moe_q, moe_d;
  logic           wr_ok;

  assign wr_ok = wp_s && !(prot_en && in_prot(wr_sector, prot_lo, prot_hi));

  always_comb begin
    st_d  = st_q;
    tmr_d = tmr_q;
    wg_d  = 1'b0;
    wj_d  = 1'b0;
    rg_d  = rd_req && (st_q == SFP_ARR_IDLE);
    rj_d  = rd_req && (st_q == SFP_ARR_BUSY);
    case (st_q)
      SFP_ARR_IDLE: begin
        if (wr_req) begin
          wg_d = wr_ok;
          wj_d = !wr_ok;
          if (wr_ok) begin
            st_d  = SFP_ARR_BUSY;
            tmr_d = 20'(TWP_CYC - 1);
          end
        end
      end
      SFP_ARR_BUSY: begin
        wj_d = wr_req;
        if (tmr_q == 20'h0) st_d = SFP_ARR_IDLE;
        else tmr_d = tmr_q - 20'h1;
      end
      default: st_d = SFP_ARR_IDLE;
    endcase
    sb_d2 = cs_s && (st_d == SFP_ARR_IDLE);
    moe_d = mfp_func == `SFP_MFP_RDYBSY;
    mo_d  = st_d == SFP_ARR_IDLE;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q  <= SFP_ARR_IDLE;
      tmr_q <= 20'h0;
      wg_q  <= 1'b0;
      wj_q  <= 1'b0;
      rg_q  <= 1'b0;
      rj_q  <= 1'b0;
      sb_q2 <= 1'b1;
      mo_q  <= 1'b1;
      moe_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      tmr_q <= tmr_d;
      wg_q  <= wg_d;
      wj_q  <= wj_d;
      rg_q  <= rg_d;
      rj_q  <= rj_d;
      sb_q2 <= sb_d2;
      mo_q  <= mo_d;
      moe_q <= moe_d;
    end
  end

  assign so_o       = so_q;
  assign so_oe      = so_oe_q;
  assign mfp_o      = mo_q;
  assign mfp_oe     = moe_q;
  assign rx_overrun = ovr_q;
  assign tx_ready   = txr_q;
  assign wr_grant   = wg_q;
  assign wr_reject  = wj_q;
  assign rd_grant   = rg_q;
  assign rd_reject  = rj_q;
  assign arr_busy   = st_q == SFP_ARR_BUSY;
  assign standby    = sb_q2;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_grant;
    wr_req && !arr_busy && wr_ok;
  endsequence
  sequence s_busy_run;
    arr_busy[*8];
  endsequence

  a_so_desel: assert property (cs_s |=> !so_oe)
    else $error("data output driven while deselected");
  a_so_pause: assert property (pause |=> !so_oe)
    else $error("data output driven while paused");
  a_unarmed_idle: assert property (!armed_q |-> !rx_push)
    else $error("byte taken before first deselect");
  a_rise_shift: assert property (run && sck_rise |=> bit_cnt_q == $past(bit_cnt_q) + 3'h1)
    else $error("rising edge not counted");
  a_pause_freeze: assert property (pause && !cs_s |=> $stable(bit_cnt_q) && $stable(obit_q))
    else $error("shift state moved while paused");
  a_edge_select: assert property (run && !read_edge_select && sck_rise && !sck_fall
                                  |=> $stable(obit_q))
    else $error("output shifted on wrong edge");
  a_wp_block: assert property (wr_req && !wp_s |=> wr_reject && !wr_grant)
    else $error("write granted with protect pin low");
  a_range_block: assert property (wr_req && prot_en && in_prot(wr_sector, prot_lo, prot_hi)
                                  |=> !wr_grant)
    else $error("write granted in protected range");
  a_busy_hold: assert property (s_grant |=> s_busy_run)
    else $error("busy ended too early");
  a_read_refuse: assert property (rd_req && arr_busy |=> rd_reject && !rd_grant)
    else $error("read granted while busy");
  a_standby_wait: assert property (cs_s && arr_busy ##1 arr_busy |-> !standby)
    else $error("standby entered during programming");
  a_mfp_nc: assert property (mfp_func == `SFP_MFP_NC |=> !mfp_oe)
    else $error("pin driven while unconnected");
endmodule

// ==== sim/sfp_host.sv ====
`timescale 1ns/10ps
module sfp_host (
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  output logic      hold_n,
  input  wire logic so_o,
  input  wire logic so_oe,
  input  wire logic redge
);
  logic so_last;
  logic so_line;
  logic so_off_seen;
  // no pull on the line: a floating output reads back as the inverse of its last value
  always @(so_o, so_oe) if (so_oe) so_last = so_o;
  assign so_line = so_oe ? so_o : ~so_last;
  initial begin
    sck = 0; cs_n = 1; si = 1; hold_n = 1; so_last = 1; so_off_seen = 0;
  end
  // 64 ns period, below the 16 MHz ceiling of the 5 V part; sck rests low between frames
  task automatic frame(input int n, input logic [7:0] d, input bit pz, output logic [7:0] r);
    cs_n = 0; #200;
    for (int b = 0; b < 8 * n; b++) begin
      si = d[7 - b % 8];
      #30 if (redge) r = {r[6:0], so_line};
      #2 sck = 1;
      #30 if (!redge) r = {r[6:0], so_line};
      if (pz && b == 3) begin
        hold_n = 0; si = ~si; #100 so_off_seen = !so_oe;
        sck = 0; #32 sck = 1; #100 hold_n = 1; #100;
      end
      #2 sck = 0;
    end
    #100 cs_n = 1; si = ~si; #200;
  endtask
endmodule

// ==== sim/tb_serial_flash_spi_pin_frontend.sv ====
`timescale 1ns/10ps
`include "sfp_map.svh"
`define CHK(a, e) begin \
  logic [31:0] av, ev; \
  av = 32'(a); \
  ev = 32'(e); \
  compares++; \
  if (av !== ev) begin \
    error_cnt++; \
    $display("ERROR t=%0t got %h exp %h", $time, av, ev); \
  end \
end
module tb_serial_flash_spi_pin_frontend
  import sfp_pkg::*;
;
  typedef struct packed {
    logic wp; logic pen; logic [`SFP_SEC_W-1:0] lo; logic [`SFP_SEC_W-1:0] hi;
    logic [`SFP_SEC_W-1:0] sec; logic ok;
  } sfp_row_t;
  sfp_row_t rows [8] = '{
    '{1'h0, 1'h0, 11'h000, 11'h000, 11'h005, 1'h0}, '{1'h1, 1'h0, 11'h000, 11'h000, 11'h005, 1'h1},
    '{1'h1, 1'h1, 11'h004, 11'h008, 11'h004, 1'h0}, '{1'h1, 1'h1, 11'h004, 11'h008, 11'h008, 1'h0},
    '{1'h1, 1'h1, 11'h004, 11'h008, 11'h009, 1'h1}, '{1'h1, 1'h1, 11'h004, 11'h008, 11'h003, 1'h1},
    '{1'h0, 1'h1, 11'h004, 11'h008, 11'h009, 1'h0}, '{1'h1, 1'h1, 11'h000, 11'h7FE, 11'h7FF, 1'h1}};
  logic                  clk, rst_n, sck, cs_n, si, wp_n, mfp_i, so_o, so_oe, mfp_o, mfp_oe;
  logic                  read_edge_select, prot_en, rx_first, rx_valid, rx_ready, rx_overrun;
  logic                  tx_valid, tx_ready, wr_req, wr_grant, wr_reject, rd_req, rd_grant;
  logic                  rd_reject, arr_busy, standby, g, j;
  logic [1:0]            mfp_func;
  logic [`SFP_SEC_W-1:0] prot_lo, prot_hi, wr_sector;
  sfp_byte_t             rx_data, tx_data, r;
  logic [8:0]            q [$];
  int                    error_cnt = 0;
  int                    compares = 0;
  int                    ovr = 0;
  int                    txn = 0;

  sfp_frontend #(.TWP_CYC(16)) uut (
    .clk, .rst_n, .sck, .cs_n, .si, .wp_n, .mfp_i, .so_o, .so_oe, .mfp_o, .mfp_oe,
    .read_edge_select, .mfp_func, .prot_lo, .prot_hi, .prot_en, .rx_data, .rx_first,
    .rx_valid, .rx_ready, .rx_overrun, .tx_data, .tx_valid, .tx_ready, .wr_req, .wr_sector,
    .wr_grant, .wr_reject, .rd_req, .rd_grant, .rd_reject, .arr_busy, .standby);
  sfp_host host (.sck, .cs_n, .si, .hold_n(mfp_i), .so_o, .so_oe, .redge(read_edge_select));

  initial clk = 0;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    if (rx_valid && rx_ready) q.push_back({rx_first, rx_data});
    if (rx_overrun) ovr++;
    if (tx_ready && so_oe) txn++;
  end

  task automatic finish_test;
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // grant and reject are one-cycle pulses, so they are collected over a short window
  task automatic arr(input logic w, input logic [`SFP_SEC_W-1:0] s, output logic gg,
                     output logic jj);
    @(negedge clk) begin wr_req = w; rd_req = !w; wr_sector = s; end
    gg = 0; jj = 0;
    repeat (3) @(negedge clk) begin
      gg |= w ? wr_grant : rd_grant; jj |= w ? wr_reject : rd_reject;
      wr_req = 0; rd_req = 0;
    end
  endtask

  initial begin
    #300000;
    error_cnt++;
    finish_test();
  end

  initial begin
    rst_n = 0; wr_req = 0; rd_req = 0; wr_sector = '0; wp_n = 1; prot_en = 0;
    prot_lo = '0; prot_hi = '0; mfp_func = `SFP_MFP_RDYBSY; read_edge_select = 0;
    rx_ready = 1; tx_valid = 1; tx_data = 8'h3C;
    repeat (6) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    `CHK(standby, 1'h1)
    `CHK(so_oe, 1'h0)
    host.frame(1, 8'hA5, 0, r);
    repeat (8) @(negedge clk);
    `CHK(q.size(), 0)
    $display("test arming done");
    for (int e = 0; e < 2; e++) begin
      @(negedge clk) begin read_edge_select = e[0]; tx_data = e ? 8'h96 : 8'hC3; end
      host.frame(1, e ? 8'h81 : 8'h7E, 0, r);
      repeat (8) @(negedge clk);
      `CHK(r, tx_data)
      `CHK(q.pop_front(), {1'h1, e ? 8'h81 : 8'h7E})
      `CHK(so_oe, 1'h0)
    end
    $display("test edges done");
    @(negedge clk) mfp_func = `SFP_MFP_PAUSE;
    host.frame(1, 8'hB4, 1, r);
    repeat (8) @(negedge clk);
    `CHK(host.so_off_seen, 1'h1)
    `CHK(r, tx_data)
    `CHK(q.pop_front(), {1'h1, 8'hB4})
    $display("test pause done");
    @(negedge clk) begin rx_ready = 0; txn = 0; end
    host.frame(3, 8'h69, 0, r);
    repeat (8) @(negedge clk);
    `CHK(ovr, 1)
    `CHK(txn, 3)
    rx_ready = 1;
    repeat (4) @(negedge clk);
    `CHK(q.size(), 2)
    `CHK(q.pop_front(), {1'h1, 8'h69})
    `CHK(q.pop_front(), {1'h0, 8'h69})
    $display("test stall done");
    foreach (rows[i]) begin
      @(negedge clk) begin
        wp_n = rows[i].wp; prot_en = rows[i].pen; prot_lo = rows[i].lo; prot_hi = rows[i].hi;
      end
      repeat (4) @(negedge clk);
      arr(1, rows[i].sec, g, j);
      `CHK(g, rows[i].ok)
      `CHK(j, !rows[i].ok)
      repeat (20) @(negedge clk);
    end
    $display("test protect done");
    @(negedge clk) begin mfp_func = `SFP_MFP_RDYBSY; wp_n = 1; prot_en = 0; end
    repeat (4) @(negedge clk);
    arr(1, 11'h010, g, j);
    `CHK(g, 1'h1)
    `CHK({arr_busy, mfp_oe, mfp_o, standby}, 4'hC)
    arr(1, 11'h011, g, j);
    `CHK(j, 1'h1)
    arr(0, '0, g, j);
    `CHK(j, 1'h1)
    repeat (16) @(negedge clk);
    `CHK({arr_busy, mfp_o, standby}, 3'h3)
    arr(0, '0, g, j);
    `CHK(g, 1'h1)
    @(negedge clk) mfp_func = `SFP_MFP_NC;
    repeat (2) @(negedge clk);
    `CHK(mfp_oe, 1'h0)
    $display("test busy done");
    finish_test();
  end
endmodule
